// ==== shared/sbs_params.svh ====
`ifndef SBS_PARAMS_SVH
`define SBS_PARAMS_SVH
`define SBS_ADDR_W      15
`define SBS_LANES       4
`define SBS_LANE_W      9
`define SBS_BURST_W     2
`define SBS_WORDS       32768
`endif

// ==== shared/sbs_pkg.sv ====
package sbs_pkg;
	typedef enum logic [1:0] {
		SBS_IDLE  = 2'b00,
		SBS_READ  = 2'b01,
		SBS_WRITE = 2'b10
	} sbs_cycle_t;

	typedef struct packed {
		logic primaryChipEnableN;
		logic depthEnableHigh;
		logic depthEnableLow;
		logic processorAddrStrobeN;
		logic controllerAddrStrobeN;
		logic burstAdvanceN;
		logic globalWriteN;
		logic plainWriteN;
		logic [3:0] laneWriteN;
	} sbs_ctrl_t;
endpackage

// ==== verilog/sbs_sram_core.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sbs_params.svh"
// Function
// - Selected only with depth-high enable 1 and depth-low enable 0.
// - Global write strobe low writes every byte lane.
// - Plain write low, global high: write only lanes whose strobe is low.
// - Write when global low, or plain low with any lane strobe low.
// - Deselect and float data in the three listed enable/strobe cases.
// - Processor strobe start, or controller start with no write indicated, begins a read; processor start always reads.
// - Controller start with write strobes indicating write begins a write.
// - Both strobes idle, advance high, write indicated: write at current address.
// - No new start and advance low: step burst counter, continue cycle.
// - No new start and advance high: hold counter, repeat cycle.
// - Write cycles keep data pins floating regardless of output enable.
// - Output enable is unclocked; read data driven while it is low.
// - Primary enable high ignores processor strobe; controller strobe low deselects.
// - Two-bit burst counter, linear or interleaved by burst order pin.
module sbs_sram_core #(
	parameter int ADDR_W = `SBS_ADDR_W,
	parameter int LANES  = `SBS_LANES,
	parameter int LANE_W = `SBS_LANE_W
) (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   arst_n,
	// Synchronous controls
	input  wire sbs_pkg::sbs_ctrl_t     ctrlIn,
	input  wire logic [ADDR_W-1:0]      wordAddressIn,
	// Asynchronous controls
	input  wire logic                   outputEnableN,
	input  wire logic                   burstOrderSelect,
	input  wire logic                   sleepRequest,
	// Data pins
	input  wire logic [LANES*LANE_W-1:0] dataLaneIn,
	output logic [LANES*LANE_W-1:0]      dataLaneOut,
	output logic [LANES*LANE_W-1:0]      dataLaneOe,
	// Status
	output logic                        cycleIsWrite
);
	import sbs_pkg::*;

	localparam int DATA_W = LANES * LANE_W;
	localparam int WORDS  = 1 << ADDR_W;

	localparam int HIGH_W = ADDR_W - `SBS_BURST_W;

	// Geometry checks at elaboration
	if (ADDR_W <= `SBS_BURST_W)
	begin : g_bad_addr
		$error("sbs_sram_core: address narrower than the burst counter");
	end
	if (LANES != `SBS_LANES)
	begin : g_bad_lanes
		$error("sbs_sram_core: lane count must match the lane strobes");
	end
	if (LANE_W < 1)
	begin : g_bad_width
		$error("sbs_sram_core: lane width must be positive");
	end

	function automatic logic [`SBS_BURST_W-1:0] nextBurst(
		input logic [`SBS_BURST_W-1:0] start,
		input logic [`SBS_BURST_W-1:0] step,
		input logic                    interleave
	);
		logic [`SBS_BURST_W-1:0] s;
		s = step + 2'h1;
		if (interleave)
			nextBurst = start ^ s;
		else
			nextBurst = start + s;
	endfunction

	function automatic logic [ADDR_W-1:0] wordAt(
		input logic [ADDR_W-1:0]       base,
		input logic [`SBS_BURST_W-1:0] burst
	);
		logic [HIGH_W-1:0] high;
		high   = base[ADDR_W-1:`SBS_BURST_W];
		wordAt = {high, burst};
	endfunction

	function automatic logic [LANES-1:0] laneMask(
		input sbs_ctrl_t ctrl
	);
		if (!ctrl.globalWriteN)
			laneMask = '1;
		else if (!ctrl.plainWriteN)
			laneMask = LANES'(~ctrl.laneWriteN);
		else
			laneMask = '0;
	endfunction

	// Input sampling
	sbs_ctrl_t                ctrlQ;
	logic [ADDR_W-1:0]        addrInQ;
	logic [DATA_W-1:0]        dataInQ;
	logic                     orderMetaQ;
	logic                     orderSyncQ;
	logic                     sleepMetaQ;
	logic                     sleepSyncQ;

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			ctrlQ <= '1;
		else
			ctrlQ <= ctrlIn;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			addrInQ <= '0;
		else
			addrInQ <= wordAddressIn;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			dataInQ <= '0;
		else
			dataInQ <= dataLaneIn;
	end

	// Order and sleep pins are slow; two flops guard against metastability
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			orderMetaQ <= 1'b0;
			orderSyncQ <= 1'b0;
		end
		else
		begin
			orderMetaQ <= burstOrderSelect;
			orderSyncQ <= orderMetaQ;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sleepMetaQ <= 1'b0;
			sleepSyncQ <= 1'b0;
		end
		else
		begin
			sleepMetaQ <= sleepRequest;
			sleepSyncQ <= sleepMetaQ;
		end
	end

	// Cycle decode
	logic                   depthOk;
	logic                   procStart;
	logic                   ctrlStart;
	logic                   deselect;
	logic                   writeInd;
	logic [LANES-1:0]       laneWr;

	// Select and start decode
	always_comb
	begin
		depthOk   = ctrlQ.depthEnableHigh && !ctrlQ.depthEnableLow;
		procStart = !ctrlQ.processorAddrStrobeN && !ctrlQ.primaryChipEnableN;
		ctrlStart = !procStart && !ctrlQ.controllerAddrStrobeN;
		deselect  = (ctrlStart && ctrlQ.primaryChipEnableN)
			|| ((procStart || ctrlStart) && !depthOk);
	end

	// Write strobe decode
	always_comb
	begin
		laneWr   = laneMask(ctrlQ);
		writeInd = |laneWr;
	end

	// Cycle state, address and burst counter
	sbs_cycle_t              cycleQ;
	logic [ADDR_W-1:0]       baseQ;
	logic [`SBS_BURST_W-1:0] stepQ;
	logic [`SBS_BURST_W-1:0] burstQ;
	logic                    anyStart;
	logic                    goOn;
	logic [`SBS_BURST_W-1:0] burstNext;
	logic [ADDR_W-1:0]       wrAddr;
	logic                    wrEn;

	// Next burst position and the word written at this edge
	always_comb
	begin
		anyStart  = (procStart || ctrlStart) && !deselect;
		goOn      = !procStart && !ctrlStart && (cycleQ != SBS_IDLE);
		burstNext = burstQ;
		if (goOn && !ctrlQ.burstAdvanceN)
			burstNext = nextBurst(baseQ[`SBS_BURST_W-1:0], stepQ, orderSyncQ);
		if (anyStart)
		begin
			wrAddr = addrInQ;
			wrEn   = ctrlStart && writeInd && !sleepSyncQ;
		end
		else
		begin
			wrAddr = wordAt(baseQ, burstNext);
			wrEn   = goOn && writeInd && !sleepSyncQ;
		end
	end

	// A processor-strobe start never writes; its data follows on a later edge
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			cycleQ <= SBS_IDLE;
		else if (deselect)
			cycleQ <= SBS_IDLE;
		else if (procStart)
			cycleQ <= SBS_READ;
		else if (ctrlStart)
		begin
			if (writeInd)
				cycleQ <= SBS_WRITE;
			else
				cycleQ <= SBS_READ;
		end
		else if (cycleQ != SBS_IDLE)
			cycleQ <= writeInd ? SBS_WRITE : SBS_READ;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			baseQ <= '0;
		else if (anyStart)
			baseQ <= addrInQ;
	end

	// Step counts from the start, so interleaving needs only an exclusive-OR
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			stepQ <= '0;
		else if (anyStart)
			stepQ <= '0;
		else if (goOn && !ctrlQ.burstAdvanceN)
			stepQ <= stepQ + 2'h1;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			burstQ <= '0;
		else if (anyStart)
			burstQ <= addrInQ[`SBS_BURST_W-1:0];
		else if (goOn)
			burstQ <= burstNext;
	end

	// The array and the word the current cycle points at
	logic [DATA_W-1:0] memArray [WORDS];
	logic [ADDR_W-1:0] curAddr;

	assign curAddr = wordAt(baseQ, burstQ);

	// Writes land with the strobes and data of the same input edge
	always_ff @(posedge clk)
	begin
		if (wrEn)
		begin
			for (int l = 0; l < LANES; l++)
			begin
				if (laneWr[l])
					memArray[wrAddr][l*LANE_W +: LANE_W] <= dataInQ[l*LANE_W +: LANE_W];
			end
		end
	end

	// Output enable stays unregistered so the bus turns within the cycle
	always_comb
	begin
		dataLaneOut = memArray[curAddr];
		dataLaneOe  = '0;
		if (cycleQ == SBS_READ && !outputEnableN)
			dataLaneOe = '1;
	end

	assign cycleIsWrite = (cycleQ == SBS_WRITE);
endmodule // sbs_sram_core
`default_nettype wire

// ==== verification/sbs_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module sbs_host_model (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Read wish and enable
	input wire logic readOk,
	output var logic outputEnableN
);
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
			outputEnableN <= 1'b1;
		else
			outputEnableN <= !readOk;
endmodule // sbs_host_model
`default_nettype wire

// ==== verification/sbs_sram_core_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module sbs_sram_core_properties (
	input wire logic clk,
	input wire logic arst_n,
	input wire sbs_pkg::sbs_ctrl_t ctrlIn,
	input wire logic outputEnableN,
	input wire logic [35:0] dataLaneOe,
	input wire logic cycleIsWrite
);
	wire logic pe=ctrlIn.primaryChipEnableN;
	wire logic ps=ctrlIn.processorAddrStrobeN;
	wire logic cs=ctrlIn.controllerAddrStrobeN;
	wire logic ok=ctrlIn.depthEnableHigh&!ctrlIn.depthEnableLow;
	wire logic gw=ctrlIn.globalWriteN;
	wire logic wr=!gw|(!ctrlIn.plainWriteN&!(&ctrlIn.laneWriteN));
	wire logic go=!ps&!pe|!cs;
	wire logic w=cycleIsWrite;
	wire logic z=dataLaneOe=='0;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	property p_ds; !cs&pe|go&!ok |-> ##2 !w&&z; endproperty
	a_ds: assert property (p_ds) else $error("deselect");
	property p_rd; go&!pe&ok&(!ps|!wr) |-> ##2 !w; endproperty
	a_rd: assert property (p_rd) else $error("read start");
	property p_wr; ps&!cs&!pe&ok&wr |-> ##2 w; endproperty
	a_wr: assert property (p_wr) else $error("write start");
	property p_gw; ps&!cs&!pe&ok&!gw |-> ##2 w; endproperty
	a_gw: assert property (p_gw) else $error("global write");
	property p_ct; cs&(ps|pe) ##1 w |-> ##1 w==$past(wr,2); endproperty
	a_ct: assert property (p_ct) else $error("continue");
	property p_wz; w |-> z; endproperty
	a_wz: assert property (p_wz) else $error("write drive");
	property p_of; outputEnableN |-> z; endproperty
	a_of: assert property (p_of) else $error("enable off");
	property p_on; !z |-> &dataLaneOe&&!outputEnableN&&!w; endproperty
	a_on: assert property (p_on) else $error("enable on");
endmodule // sbs_sram_core_properties
bind sbs_sram_core sbs_sram_core_properties u_props(.clk(clk), .arst_n(arst_n), .ctrlIn(ctrlIn),
	.outputEnableN(outputEnableN), .dataLaneOe(dataLaneOe), .cycleIsWrite(cycleIsWrite));
`default_nettype wire

// ==== verification/tb_sync_burst_sram_cycle_control.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,s) begin checkCount++; if((s)!==(e)) begin mismatches++; \
	$display("[ERR] %s exp %h got %h",n,e,s); end end
module tb_sync_burst_sram_cycle_control;
	logic clk=0, arst_n=0, rdOk=0, ord=0, oeN, isWr;
	sbs_pkg::sbs_ctrl_t c='1;
	logic [14:0] a='0;
	logic [35:0] di='0, q, e, m;
	logic [35:0] bd [4];
	logic [41:0] r;
	int mismatches=0, checkCount=0;
	always #2.5 clk=~clk;
	sbs_sram_core u_sbs_sram_core(.clk(clk), .arst_n(arst_n), .ctrlIn(c), .wordAddressIn(a),
		.outputEnableN(oeN), .burstOrderSelect(ord), .sleepRequest(1'b0), .dataLaneIn(di),
		.dataLaneOut(q), .dataLaneOe(e), .cycleIsWrite(isWr));
	sbs_host_model u_sbs_host_model(.clk(clk), .arst_n(arst_n), .readOk(rdOk),
		.outputEnableN(oeN));
	// Expected word after a write
	function automatic logic [35:0] nx(logic [35:0] o, n, logic g, w, logic [3:0] l);
		for (int k=0; k<4; k++)
			if (!g|(!w&!l[k]))
				o[9*k+:9]=n[9*k+:9];
		return o;
	endfunction
	// Start a cycle, suspend three edges, then compare
	task automatic op(logic s, p, g, w, logic [3:0] l, logic [35:0] d);
		logic wi;
		wi=s&p&(!g|(!w&!(&l)));
		@(negedge clk);
		c={1'b0, s, 1'b0, p, !p, 1'b1, g, w, l};
		di=d;
		rdOk=s&!wi;
		@(negedge clk);
		c[8:7]=2'b11;
		if (!wi)
			c[5:0]=6'h3F;
		repeat (3) @(negedge clk);
		`CHK("write", wi, isWr)
		if (wi)
			m=nx(m, d, g, w, l);
		else if (s)
		begin
			`CHK("data", m, q)
			`CHK("enable", 36'hFFFFFFFFF, e)
		end
	endtask
	// Burst position from start bits and step
	function automatic logic [1:0] bo(logic [1:0] s, k, logic o);
		return o ? s^k : s+k;
	endfunction
	// Write four words by a controller burst, then read each word back alone
	task automatic bst(logic o, logic [14:0] b);
		ord=o;
		repeat (3) @(negedge clk);
		for (int k=0; k<4; k++)
			bd[k]=36'({$urandom, $urandom});
		@(negedge clk);
		rdOk=0;
		a=b;
		c={1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 4'hF};
		di=bd[0];
		for (int k=1; k<4; k++)
		begin
			@(negedge clk);
			c[8:6]=3'b110;
			di=bd[k];
		end
		@(negedge clk);
		c[8:5]=4'hF;
		for (int k=0; k<4; k++)
		begin
			a={b[14:2], bo(b[1:0], 2'(k), o)};
			m=bd[k];
			op(1, 0, 1, 1, 4'hF, 36'h0);
		end
	endtask
	task automatic give_verdict;
		$display("%0d checks, %0d mismatches", checkCount, mismatches);
		if (mismatches==0 && checkCount>0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		void'($urandom(69603));
		repeat (10) @(negedge clk);
		arst_n=1;
		for (int i=0; i<20; i++)
		begin
			r=42'({$urandom, $urandom});
			a=r[14:0];
			op(1, 1, 0, r[15], r[19:16], r[41:6]);
			r=42'({$urandom, $urandom});
			op(r[0]|r[1], 1, r[2], r[3], r[7:4], r[41:6]);
			r=42'({$urandom, $urandom});
			op(1, 0, r[0], r[1], r[5:2], r[41:6]);
		end
		bst(0, 15'($urandom));
		bst(1, 15'h7FFF);
		bst(1, 15'h2A75);
		bst(0, 15'h7FFE);
		op(1, 1, 1, 0, 4'hF, 36'h0);
		op(1, 1, 1, 0, 4'hA, 36'h123456789);
		op(1, 0, 0, 0, 4'h0, 36'h0);
		give_verdict;
	end
	initial
	begin
		#20000;
		mismatches++;
		give_verdict;
	end
endmodule // tb_sync_burst_sram_cycle_control
`default_nettype wire
